// >>> core/rtc_top.v
/*
  Calendar clock unit slice: drift calibration, clock output pin control,
  minute and second counting and the alarm minute and second compare,
  all behind an AHB-Lite slave.
  Assumes a single AHB-Lite master, the crystal pulse on TICK_IN slower
  than CLK/4, and SYS_RST_N as the non power-on reset source.
*/
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`include "rtc_defs.vh"

module rtc_top #(
  parameter [15:0] TICKS_PER_SEC = `RTC_TICKS_PER_SEC
) (
  // Clock and resets
  input wire CLK,
  input wire ARST_N,
  input wire SYS_RST_N,
  // AHB-Lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output wire [31:0] HRDATA,
  // Crystal pulse input pin
  input wire TICK_IN,
  // Clock output pin
  output wire CLK_OUT
);

  localparam [15:0] TICK_LAST = TICKS_PER_SEC - 16'h0001;
  localparam [15:0] TICK_HALF = TICKS_PER_SEC >> 1;
  localparam [15:0] TICK_HALF_M1 = TICK_HALF - 16'h0001;

  // Carry out in bit 4, next digit in bits 3:0.
  function [4:0] bcd_step;
    input [3:0] d;
    input [3:0] last;
    begin
      if (d >= last) begin
        bcd_step = 5'h10;
      end else begin
        bcd_step = {1'b0, d + 4'h1};
      end
    end
  endfunction

  function addr_is;
    input [`RTC_OFS_W-1:0] a;
    input [`RTC_OFS_W-1:0] ofs;
    begin
      addr_is = (a == ofs);
    end
  endfunction

  // Synchronisers
  reg tick_s1_q, tick_s2_q, tick_s3_q;
  reg rst_s1_q, rst_s2_q;

  // Bus state
  reg dp_wr_q, dp_rd_q, rd_done_q;
  reg [`RTC_OFS_W-1:0] dp_addr_q;
  reg [15:0] hrdata_q;
  reg [15:0] rd_value;

  // Registers
  reg [15:0] trim_q;
  reg [15:0] trim_d;
  reg half_flag_q;
  reg src_sel_q;
  reg [14:0] alarm_q;

  // Time keeping
  reg [3:0] sec_u_q, min_u_q;
  reg [2:0] sec_t_q, min_t_q;
  reg [15:0] presc_q;
  reg [9:0] debt_q;
  reg alarm_hit_q;
  reg clk_out_q;

  wire soft_rst, hready_out, addr_phase;
  wire wr_trim, wr_pad, wr_alarm, wr_time;
  wire tick, run, step_ok;
  wire sec_end, min_end, half_set, sec_clk;
  wire [4:0] su_n, st_n, mu_n, mt_n;
  wire [15:0] time_now;
  wire [9:0] add_cnt, sub_cnt;

  // The pin and the other reset come from outside this clock.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      tick_s1_q <= TICK_IN;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      rst_s1_q <= SYS_RST_N;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign soft_rst = ~rst_s2_q;
  assign tick = tick_s2_q & ~tick_s3_q;

  // Reads take one wait state so that a write just before is seen.
  assign hready_out = ~dp_rd_q | rd_done_q;
  assign addr_phase = HSEL & HREADY & HTRANS[1];

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      rd_done_q <= 1'b0;
      dp_addr_q <= {`RTC_OFS_W{1'b0}};
      hrdata_q <= 16'h0000;
    end else if (hready_out) begin
      dp_wr_q <= addr_phase & HWRITE;
      dp_rd_q <= addr_phase & ~HWRITE;
      rd_done_q <= 1'b0;
      dp_addr_q <= HADDR[`RTC_OFS_W-1:0];
    end else begin
      rd_done_q <= 1'b1;
      hrdata_q <= rd_value;
    end
  end

  assign HREADYOUT = hready_out;
  assign HRESP = 1'b0;
  assign HRDATA = {16'h0000, hrdata_q};

  assign wr_trim = dp_wr_q & addr_is(dp_addr_q, `RTC_OFS_TRIM);
  assign wr_pad = dp_wr_q & addr_is(dp_addr_q, `RTC_OFS_PAD);
  assign wr_alarm = dp_wr_q & addr_is(dp_addr_q, `RTC_OFS_ALARM);
  assign wr_time = dp_wr_q & addr_is(dp_addr_q, `RTC_OFS_TIME);

  assign time_now = {1'b0, min_t_q, min_u_q, 1'b0, sec_t_q, sec_u_q};

  always @* begin
    rd_value = 16'h0000;
    case (dp_addr_q)
      `RTC_OFS_TRIM: begin
        rd_value = trim_q;
        rd_value[`RTC_HALF_FLAG_BIT] = half_flag_q;
      end
      `RTC_OFS_PAD: begin
        rd_value[`RTC_SRC_SEL_BIT] = src_sel_q;
      end
      `RTC_OFS_ALARM: begin
        rd_value = {1'b0, alarm_q} & `RTC_BCD_MASK;
      end
      `RTC_OFS_TIME: begin
        rd_value = time_now;
      end
      default: begin
        rd_value = 16'h0000;
      end
    endcase
  end

  // Trim register write; the run bit is guarded by the permit bit.
  always @* begin
    trim_d = trim_q;
    if (wr_trim) begin
      trim_d[`RTC_CAL_MSB:`RTC_CAL_LSB] = HWDATA[`RTC_CAL_MSB:`RTC_CAL_LSB];
      trim_d[`RTC_OUT_EN_BIT] = HWDATA[`RTC_OUT_EN_BIT];
      trim_d[`RTC_WR_PERMIT_BIT] = HWDATA[`RTC_WR_PERMIT_BIT];
      if (trim_q[`RTC_WR_PERMIT_BIT]) begin
        trim_d[`RTC_RUN_EN_BIT] = HWDATA[`RTC_RUN_EN_BIT];
      end
    end
  end

  // Only the power-on reset reaches the trim register and its flag.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      trim_q <= `RTC_TRIM_RST;
    end else begin
      trim_q <= trim_d;
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      half_flag_q <= 1'b0;
    end else begin
      half_flag_q <= half_set | (half_flag_q & ~wr_time);
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      src_sel_q <= 1'b0;
    end else if (soft_rst) begin
      src_sel_q <= 1'b0;
    end else if (wr_pad) begin
      src_sel_q <= HWDATA[`RTC_SRC_SEL_BIT];
    end
  end

  // Alarm digits carry no reset and power up unknown.
  always @(posedge CLK) begin
    if (wr_alarm) begin
      alarm_q[`RTC_MT_MSB:`RTC_MT_LSB] <= HWDATA[`RTC_MT_MSB:`RTC_MT_LSB];
      alarm_q[`RTC_MU_MSB:`RTC_MU_LSB] <= HWDATA[`RTC_MU_MSB:`RTC_MU_LSB];
      alarm_q[7] <= 1'b0;
      alarm_q[`RTC_ST_MSB:`RTC_ST_LSB] <= HWDATA[`RTC_ST_MSB:`RTC_ST_LSB];
      alarm_q[`RTC_SU_MSB:`RTC_SU_LSB] <= HWDATA[`RTC_SU_MSB:`RTC_SU_LSB];
    end
  end

  // Both counts are registered in rtc_trim from the same byte, so a write
  // landing right at the minute boundary takes effect at the next one.
  rtc_trim u_trim (
    .clk(CLK),
    .arst_n(ARST_N),
    .cal(trim_q[`RTC_CAL_MSB:`RTC_CAL_LSB]),
    .add_cnt(add_cnt),
    .sub_cnt(sub_cnt)
  );

  assign run = trim_q[`RTC_RUN_EN_BIT];
  assign step_ok = run & tick & (debt_q == 10'h000);
  assign sec_end = step_ok & (presc_q >= TICK_LAST);
  assign half_set = step_ok & (presc_q == TICK_HALF_M1);
  assign su_n = bcd_step(sec_u_q, `RTC_LAST_UNITS);
  assign st_n = bcd_step({1'b0, sec_t_q}, `RTC_LAST_TENS);
  assign mu_n = bcd_step(min_u_q, `RTC_LAST_UNITS);
  assign mt_n = bcd_step({1'b0, min_t_q}, `RTC_LAST_TENS);
  assign min_end = su_n[4] & st_n[4];

  // Swallowed pulses are held in debt_q and stall the prescaler.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      presc_q <= 16'h0000;
      debt_q <= 10'h000;
    end else if (soft_rst) begin
      presc_q <= 16'h0000;
      debt_q <= 10'h000;
    end else if (run & tick) begin
      if (debt_q != 10'h000) begin
        debt_q <= debt_q - 10'h001;
      end else if (sec_end & min_end) begin
        presc_q <= {6'h00, add_cnt};
        debt_q <= sub_cnt;
      end else if (sec_end) begin
        presc_q <= 16'h0000;
      end else begin
        presc_q <= presc_q + 16'h0001;
      end
    end
  end

  // A software time write wins over a second that ends in that cycle.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sec_u_q <= 4'h0;
      sec_t_q <= 3'h0;
      min_u_q <= 4'h0;
      min_t_q <= 3'h0;
    end else if (soft_rst) begin
      sec_u_q <= 4'h0;
      sec_t_q <= 3'h0;
      min_u_q <= 4'h0;
      min_t_q <= 3'h0;
    end else if (wr_time) begin
      sec_u_q <= HWDATA[`RTC_SU_MSB:`RTC_SU_LSB];
      sec_t_q <= HWDATA[`RTC_ST_MSB:`RTC_ST_LSB];
      min_u_q <= HWDATA[`RTC_MU_MSB:`RTC_MU_LSB];
      min_t_q <= HWDATA[`RTC_MT_MSB:`RTC_MT_LSB];
    end else if (sec_end) begin
      sec_u_q <= su_n[3:0];
      if (su_n[4]) begin
        sec_t_q <= st_n[2:0];
      end
      if (min_end) begin
        min_u_q <= mu_n[3:0];
        if (mu_n[4]) begin
          min_t_q <= mt_n[2:0];
        end
      end
    end
  end

  // Seconds clock is high for the first half of each second.
  assign sec_clk = run & (presc_q < TICK_HALF);

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      alarm_hit_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else if (soft_rst) begin
      alarm_hit_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else begin
      alarm_hit_q <= run & (time_now == {1'b0, alarm_q});
      if (trim_q[`RTC_OUT_EN_BIT]) begin
        clk_out_q <= src_sel_q ? sec_clk : alarm_hit_q;
      end else begin
        clk_out_q <= 1'b0;
      end
    end
  end

  assign CLK_OUT = clk_out_q;

endmodule

// >>> core/rtc_defs.vh
/*
  Constants for the calendar clock trim, output and alarm block: register
  offsets, field positions, a read mask, reset values and timing counts.
  Assumes it is included by its bare name from the design files.
*/
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// Register byte offsets within the slave window.
`define RTC_OFS_TRIM 12'h000
`define RTC_OFS_PAD 12'h004
`define RTC_OFS_ALARM 12'h008
`define RTC_OFS_TIME 12'h00c
`define RTC_OFS_W 12

// Fields of clock_trim_and_config.
`define RTC_CAL_MSB 7
`define RTC_CAL_LSB 0
`define RTC_OUT_EN_BIT 10
`define RTC_HALF_FLAG_BIT 11
`define RTC_WR_PERMIT_BIT 13
`define RTC_RUN_EN_BIT 15

// Field of pad_output_config.
`define RTC_SRC_SEL_BIT 1

// BCD fields of alarm_minute_second and current_minute_second.
`define RTC_MT_MSB 14
`define RTC_MT_LSB 12
`define RTC_MU_MSB 11
`define RTC_MU_LSB 8
`define RTC_ST_MSB 6
`define RTC_ST_LSB 4
`define RTC_SU_MSB 3
`define RTC_SU_LSB 0
`define RTC_BCD_MASK 16'h7f7f

// Last legal digit values.
`define RTC_LAST_UNITS 4'h9
`define RTC_LAST_TENS 4'h5

// Reset values.
`define RTC_TRIM_RST 16'h0000
`define RTC_PAD_RST 16'h0000
`define RTC_TIME_RST 16'h0000

// Calibration: each count is this many crystal pulses, as a shift.
`define RTC_CAL_SHIFT 2

// Crystal pulses per second.
`define RTC_TICKS_PER_SEC 32768

`endif

// >>> core/rtc_trim.v
/*
  Turns the signed calibration byte into a count of crystal pulses to add
  or to swallow at the next minute boundary.
  Assumes the byte comes from a register on the same clock.
*/
`include "rtc_defs.vh"

module rtc_trim (
  // Clock and power-on reset
  input wire clk,
  input wire arst_n,
  // Calibration byte, two's complement
  input wire [7:0] cal,
  // Pulse counts, at most one of them non-zero
  output wire [9:0] add_cnt,
  output wire [9:0] sub_cnt
);

  reg [9:0] add_q;
  reg [9:0] sub_q;
  wire [8:0] mag;

  // Magnitude of a negative value; 8'h80 gives 128.
  assign mag = {1'b0, ~cal} + 9'h001;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      add_q <= 10'h000;
      sub_q <= 10'h000;
    end else if (cal[7]) begin
      add_q <= 10'h000;
      sub_q <= {mag[7:0], 2'b00};
    end else begin
      add_q <= {cal, 2'b00};
      sub_q <= 10'h000;
    end
  end

  assign add_cnt = add_q;
  assign sub_cnt = sub_q;

endmodule

// >>> sim/rtc_top_assertions.sv
/*
  Checker for rtc_top: bus wait states, read-back of unused bits and the pin gate.
  Assumes one AHB-Lite master with HREADY fed from HREADYOUT.
*/
module rtc_chk (
  // Clock and reset
  input wire CLK,
  input wire ARST_N,
  // Bus
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  input wire HREADYOUT,
  input wire HRESP,
  input wire [31:0] HRDATA,
  // Pin
  input wire CLK_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_v_q, ph_w_q, oe_q;
  logic [11:0] ph_a_q;
  wire tk = HSEL & HREADY & HTRANS[1];
  wire rd_done = ph_v_q & !ph_w_q & HREADYOUT;
  // Mirrors the output-enable bit, since only the ports are visible here.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ph_v_q <= 1'h0;
      ph_w_q <= 1'h0;
      ph_a_q <= 12'h0;
      oe_q <= 1'h0;
    end else begin
      if (ph_v_q & ph_w_q & HREADY & (ph_a_q == 12'h0))
        oe_q <= HWDATA[10];
      if (HREADY) begin
        ph_v_q <= tk;
        ph_w_q <= HWRITE;
        ph_a_q <= HADDR[11:0];
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  okay_resp_a:
    assert property (HRESP == 1'h0) else $error("response not OKAY");
  read_wait_a:
    assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT) else $error("read wait");
  write_nowait_a:
    assert property (tk && HWRITE |=> HREADYOUT) else $error("write stalled");
  wait_cause_a:
    assert property (!HREADYOUT |-> ph_v_q && !ph_w_q && $past(HREADYOUT))
      else $error("stray wait state");
  upper_zero_a:
    assert property (HRDATA[31:16] == 16'h0) else $error("upper read bits set");
  trim_gaps_a:
    assert property (rd_done && ph_a_q == 12'h0 |-> HRDATA[9:8] == 2'h0 && !HRDATA[12]
      && !HRDATA[14]) else $error("trim gap bits set");
  pad_gaps_a:
    assert property (rd_done && ph_a_q == 12'h4 |-> HRDATA[15:2] == 14'h0)
      else $error("pad gap bits set");
  alarm_gaps_a:
    assert property (rd_done && ph_a_q == 12'h8 |-> !HRDATA[15] && !HRDATA[7])
      else $error("alarm gap bits set");
  unmapped_zero_a:
    assert property (rd_done && ph_a_q >= 12'h10 |-> HRDATA == 32'h0)
      else $error("unmapped read not zero");
  pin_gate_a:
    assert property (!oe_q |=> !CLK_OUT) else $error("pin driven while disabled");
endmodule
bind rtc_top rtc_chk u_rtc_chk (.CLK, .ARST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
  .HREADY, .HREADYOUT, .HRESP, .HRDATA, .CLK_OUT);

// >>> sim/tb_rtc_top.sv
/*
  Self-checking bench for rtc_top: bus tasks and one task per scenario.
  Assumes rtc_top is the only slave, so HREADYOUT is fed back as HREADY.
*/
module tb_rtc_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TPS = 520;
  logic CLK = '0, ARST_N = '0, SYS_RST_N = '1, HSEL = '0, HWRITE = '0, TICK_IN = '0;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, v;
  logic [1:0] HTRANS = '0;
  logic [2:0] HSIZE = 3'h2;
  logic HREADYOUT, HRESP, CLK_OUT;
  int n_errors = 0, comparisons = 0, n;
  always #2.5 CLK = ~CLK;
  rtc_top #(.TICKS_PER_SEC(16'h208)) u_rtc_top (.CLK, .ARST_N, .SYS_RST_N, .HSEL, .HADDR,
    .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HREADYOUT, .HRESP, .HRDATA,
    .TICK_IN, .CLK_OUT);
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge CLK);
  endtask
  task ap(input [11:0] a, input logic w);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {20'h0, a};
    @(posedge CLK);
    while (!HREADYOUT) @(posedge CLK);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
  endtask
  task wr(input [11:0] a, input [15:0] d);
    ap(a, 1'h1);
    HWDATA <= {16'h0, d};
    @(posedge CLK);
    while (!HREADYOUT) @(posedge CLK);
  endtask
  task rd(input [11:0] a);
    ap(a, 1'h0);
    @(posedge CLK);
    while (!HREADYOUT) @(posedge CLK);
    v = HRDATA;
  endtask
  task rc(input [11:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask
  // Pulses are spaced well beyond the three cycles the synchroniser needs.
  task tick;
    TICK_IN <= 1'h1;
    cyc(1);
    TICK_IN <= 1'h0;
    cyc(4);
  endtask
  task run_to(input [15:0] t);
    n = 0;
    do begin
      tick();
      n++;
      rd(12'h00c);
    end while (v[15:0] !== t && n < 2000);
  endtask
  task sysrst;
    SYS_RST_N <= 1'h0;
    cyc(4);
    SYS_RST_N <= 1'h1;
    cyc(4);
  endtask
  task t_regs;
    rc(12'h000, 32'h0);
    rc(12'h004, 32'h0);
    rc(12'h00c, 32'h0);
    wr(12'h004, 16'hffff);
    rc(12'h004, 32'h2);
    wr(12'h008, 16'hffff);
    rc(12'h008, 32'h7f7f);
    wr(12'h008, 16'h5947);
    rc(12'h008, 32'h5947);
    wr(12'h020, 16'hffff);
    rc(12'h020, 32'h0);
    $display("test regs done");
  endtask
  task t_permit;
    wr(12'h000, 16'h8000);
    rc(12'h000, 32'h0);
    wr(12'h000, 16'h2800);
    rc(12'h000, 32'h2000);
    wr(12'h000, 16'ha000);
    rc(12'h000, 32'ha000);
    $display("test permit done");
  endtask
  task t_pin;
    sysrst();
    wr(12'h000, 16'ha400);
    wr(12'h004, 16'h2);
    cyc(3);
    chk({31'h0, CLK_OUT}, 32'h1);
    wr(12'h008, 16'h1234);
    wr(12'h004, 16'h0);
    cyc(3);
    chk({31'h0, CLK_OUT}, 32'h0);
    wr(12'h008, 16'h0);
    cyc(3);
    chk({31'h0, CLK_OUT}, 32'h1);
    wr(12'h000, 16'ha000);
    cyc(3);
    chk({31'h0, CLK_OUT}, 32'h0);
    $display("test pin done");
  endtask
  task t_cal;
    logic [7:0] c [5] = '{8'h00, 8'h01, 8'hff, 8'h7f, 8'h80};
    foreach (c[i]) begin
      // The trim byte changes only while no pulses arrive.
      wr(12'h000, {8'ha0, c[i]});
      sysrst();
      // The half flag set in an earlier pass survives the soft reset.
      rc(12'h000, {16'h0, (i == 0) ? 8'ha0 : 8'ha8, c[i]});
      wr(12'h00c, 16'h0059);
      run_to(16'h0100);
      chk(n, TPS);
      run_to(16'h0101);
      chk(n, TPS - 4 * $signed(c[i]));
    end
    rd(12'h000);
    chk(v & 32'h800, 32'h800);
    wr(12'h00c, 16'h0);
    rd(12'h000);
    chk(v & 32'h800, 32'h0);
    $display("test calibration done");
  endtask
  task t_por;
    ARST_N <= 1'h0;
    cyc(2);
    ARST_N <= 1'h1;
    cyc(1);
    rc(12'h000, 32'h0);
    $display("test power-on reset done");
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #450us;
    n_errors++;
    close_out();
  end
  initial begin
    cyc(3);
    ARST_N <= 1'h1;
    t_regs();
    t_permit();
    t_pin();
    t_cal();
    t_por();
    close_out();
  end
endmodule
